// ==== src/tcs_top.sv ====
// trigger and capture sequencer of a synchronous bus-state recorder
// assumes an AHB-Lite master on SYS_CLK and probe pins from a foreign clock
//
// Notes on behaviour
// - store holds 64 words of 27 bits
// - parameters persist until rewritten or reset
// - zero delay: 31 before, trigger, 32 after
// - clock delay shifts window by that many
// - event delay N: window around (N+1)th match
// - event count begins after first stage met
// - one word per qualified external clock cycle
// - configuration picks rising or falling sample edge
// - both sample qualifiers must equal programmed levels
// - search first stage, then second stage
// - patterns: 16 address, 8 data, direction, 2 qualifiers
// - bits 24-26: direction, two pattern qualifiers
// - each stage has its own care mask
// - care masks reset to zero, matching everything
// - empty first mask skips to second stage
// - every stored word keeps all 27 lines
// - polarity mask bits invert probe channels
// - arming flushes 64 samples before searching
// - trigger output high from trigger through post
// - after post: stop, freeze, report done
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_top import tcs_pkg::*; (
  input  wire logic                   SYS_CLK,
  input  wire logic                   RST,
  input  wire logic                   HSEL,
  input  wire logic [31:0]            HADDR,
  input  wire logic [1:0]             HTRANS,
  input  wire logic                   HWRITE,
  input  wire logic [2:0]             HSIZE,
  input  wire logic [31:0]            HWDATA,
  input  wire logic                   HREADY,
  output logic      [31:0]            HRDATA,
  output logic                        HREADYOUT,
  output logic                        HRESP,
  input  wire logic [`TCS_WORD_W-1:0] PROBE_IN,
  input  wire logic                   EXT_CLK,
  input  wire logic                   SAMPLE_QUALIFIER_ONE,
  input  wire logic                   SAMPLE_QUALIFIER_TWO,
  output logic                        TRIGGER_OUT
);
  localparam int SYNC_W = `TCS_WORD_W + 3;
  localparam int CLK_B  = `TCS_WORD_W;

  // bus front end
  logic                        pend_q;
  logic                        wr_q;
  logic [7:0]                  addr_q;
  logic                        hready_q;
  logic [31:0]                 hrdata_q;
  // software parameters
  logic [3:0]                  cfg_q;
  logic [`TCS_WORD_W-1:0]      first_stage_pattern_q;
  logic [`TCS_WORD_W-1:0]      first_stage_care_mask_q;
  logic [`TCS_WORD_W-1:0]      second_stage_pattern_q;
  logic [`TCS_WORD_W-1:0]      second_stage_care_mask_q;
  logic [`TCS_WORD_W-1:0]      input_polarity_mask_q;
  logic [`TCS_DELAY_W-1:0]     clock_delay_count_q;
  logic [`TCS_DELAY_W-1:0]     event_delay_count_q;
  logic [`TCS_PTR_W-1:0]       rd_index_q;
  // sampling path
  logic [SYNC_W-1:0]           s1_q;
  logic [SYNC_W-1:0]           s2_q;
  logic [SYNC_W-1:0]           s3_q;
  logic                        clk_lvl_q;
  logic                        clk_lvl_d;
  logic                        samp_q;
  logic [`TCS_WORD_W-1:0]      word_q;
  // sequencer
  tcs_state_t                  state_q;
  tcs_state_t                  state_d;
  logic [`TCS_DELAY_W-1:0]     cnt_q;
  logic [`TCS_DELAY_W-1:0]     cnt_d;
  logic [`TCS_DELAY_W-1:0]     evt_q;
  logic [`TCS_DELAY_W-1:0]     evt_d;
  logic [`TCS_PTR_W-1:0]       wr_ptr_q;
  logic                        trig_q;

  tcs_mem_if mem_bus ();

  tcs_capture_mem u_store (
    .clk  (SYS_CLK),
    .rst  (RST),
    .port (mem_bus.store)
  );

  // address phase acceptance; every transfer gets exactly one wait state
  wire ahb_take  = HSEL & HTRANS[1] & HREADY;
  wire wr_strobe = pend_q & wr_q;
  wire rd_strobe = pend_q & ~wr_q;

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      pend_q   <= 1'b0;
      wr_q     <= 1'b0;
      addr_q   <= 8'h00;
      hready_q <= 1'b1;
    end else begin
      pend_q   <= ahb_take;
      hready_q <= ~ahb_take;
      if (ahb_take) begin
        wr_q   <= HWRITE;
        addr_q <= HADDR[7:0];
      end
    end
  end

  // register decode
  wire sel_cfg  = (addr_q == `TCS_OFS_CONFIG);
  wire sel_cmd  = (addr_q == `TCS_OFS_COMMAND);
  wire sel_sts  = (addr_q == `TCS_OFS_STATUS);
  wire sel_p1   = (addr_q == `TCS_OFS_FIRST_PAT);
  wire sel_m1   = (addr_q == `TCS_OFS_FIRST_MSK);
  wire sel_p2   = (addr_q == `TCS_OFS_SECND_PAT);
  wire sel_m2   = (addr_q == `TCS_OFS_SECND_MSK);
  wire sel_pol  = (addr_q == `TCS_OFS_POLARITY);
  wire sel_cdl  = (addr_q == `TCS_OFS_CLK_DLY);
  wire sel_edl  = (addr_q == `TCS_OFS_EVT_DLY);
  wire sel_idx  = (addr_q == `TCS_OFS_RD_INDEX);
  wire sel_dat  = (addr_q == `TCS_OFS_RD_DATA);

  // command pulses, live only in the write data phase
  wire cmd_en        = wr_strobe & sel_cmd;
  wire cmd_arm       = cmd_en & HWDATA[`TCS_CMD_ARM];
  wire cmd_force_one = cmd_en & HWDATA[`TCS_CMD_FORCE_ONE];
  wire cmd_force_two = cmd_en & HWDATA[`TCS_CMD_FORCE_TWO];
  wire cmd_stop      = cmd_en & HWDATA[`TCS_CMD_STOP];

  // parameters survive arming and recording; only a write changes them
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      cfg_q                    <= `TCS_CFG_RESET;
      first_stage_pattern_q    <= 27'h0000000;
      first_stage_care_mask_q  <= 27'h0000000;
      second_stage_pattern_q   <= 27'h0000000;
      second_stage_care_mask_q <= 27'h0000000;
      input_polarity_mask_q    <= 27'h0000000;
      clock_delay_count_q      <= 14'h0000;
      event_delay_count_q      <= 14'h0000;
      rd_index_q               <= 6'h00;
    end else if (wr_strobe) begin
      if (sel_cfg) cfg_q <= HWDATA[3:0];
      if (sel_p1)  first_stage_pattern_q    <= HWDATA[`TCS_WORD_W-1:0];
      if (sel_m1)  first_stage_care_mask_q  <= HWDATA[`TCS_WORD_W-1:0];
      if (sel_p2)  second_stage_pattern_q   <= HWDATA[`TCS_WORD_W-1:0];
      if (sel_m2)  second_stage_care_mask_q <= HWDATA[`TCS_WORD_W-1:0];
      if (sel_pol) input_polarity_mask_q    <= HWDATA[`TCS_WORD_W-1:0];
      if (sel_cdl) clock_delay_count_q      <= HWDATA[`TCS_DELAY_W-1:0];
      if (sel_edl) event_delay_count_q      <= HWDATA[`TCS_DELAY_W-1:0];
      if (sel_idx) rd_index_q               <= HWDATA[`TCS_PTR_W-1:0];
    end
  end

  // read mux; unmapped offsets and the command register read zero
  wire [31:0] sts_word = {22'h000000, trig_q, (state_q == TCS_ST_DONE), 1'b0, state_q};
  wire [31:0] rd_mux =
    sel_cfg ? {28'h0000000, cfg_q} :
    sel_sts ? sts_word :
    sel_p1  ? {5'h00, first_stage_pattern_q} :
    sel_m1  ? {5'h00, first_stage_care_mask_q} :
    sel_p2  ? {5'h00, second_stage_pattern_q} :
    sel_m2  ? {5'h00, second_stage_care_mask_q} :
    sel_pol ? {5'h00, input_polarity_mask_q} :
    sel_cdl ? {18'h00000, clock_delay_count_q} :
    sel_edl ? {18'h00000, event_delay_count_q} :
    sel_idx ? {26'h0000000, rd_index_q} :
    sel_dat ? {5'h00, mem_bus.rdata} :
    32'h00000000;

  // read data held until the next read
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      hrdata_q <= 32'h00000000;
    end else if (rd_strobe) begin
      hrdata_q <= rd_mux;
    end
  end

  // three-stage synchroniser for the external clock, qualifiers and probes
  wire [SYNC_W-1:0] pins = {SAMPLE_QUALIFIER_TWO, SAMPLE_QUALIFIER_ONE, EXT_CLK, PROBE_IN};

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s1_q <= 30'h00000000;
      s2_q <= 30'h00000000;
      s3_q <= 30'h00000000;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // clock level only moves when the last two stages agree, filtering glitches
  assign clk_lvl_d = (s2_q[CLK_B] == s3_q[CLK_B]) ? s3_q[CLK_B] : clk_lvl_q;
  wire edge_rise   = clk_lvl_d & ~clk_lvl_q;
  wire edge_fall   = ~clk_lvl_d & clk_lvl_q;
  wire edge_pick   = cfg_q[`TCS_CFG_FALLING] ? edge_fall : edge_rise;
  wire qual_ok     = (s3_q[CLK_B+1] == cfg_q[`TCS_CFG_QUAL_ONE]) &
                     (s3_q[CLK_B+2] == cfg_q[`TCS_CFG_QUAL_TWO]);
  wire samp_d      = edge_pick & qual_ok;

  // corrected word registered alongside its sample pulse
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      clk_lvl_q <= 1'b0;
      samp_q    <= 1'b0;
      word_q    <= 27'h0000000;
    end else begin
      clk_lvl_q <= clk_lvl_d;
      samp_q    <= samp_d;
      if (samp_d) begin
        word_q  <= s3_q[`TCS_WORD_W-1:0] ^ input_polarity_mask_q;
      end
    end
  end

  // masked compares; bits 24..26 are direction and the two pattern qualifiers
  wire match_one = ((word_q ^ first_stage_pattern_q) & first_stage_care_mask_q)
                   == 27'h0000000;
  wire match_two = ((word_q ^ second_stage_pattern_q) & second_stage_care_mask_q)
                   == 27'h0000000;
  wire first_off = (first_stage_care_mask_q == 27'h0000000);
  wire evt_mode  = cfg_q[`TCS_CFG_EVENT];
  wire recording = (state_q == TCS_ST_FLUSH) | (state_q == TCS_ST_SEEK1) |
                   (state_q == TCS_ST_SEEK2) | (state_q == TCS_ST_DELAY) |
                   (state_q == TCS_ST_POST);

  // sequencer next state
  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    evt_d   = evt_q;
    unique case (state_q)
      TCS_ST_IDLE, TCS_ST_DONE: begin
      end
      TCS_ST_FLUSH: begin
        if (samp_q) begin
          cnt_d = cnt_q + `TCS_CNT_ONE;
          if (cnt_q == `TCS_FLUSH_LAST) begin
            state_d = first_off ? TCS_ST_SEEK2 : TCS_ST_SEEK1;
          end
        end
      end
      TCS_ST_SEEK1: begin
        if (cmd_force_two) begin
          state_d = TCS_ST_POST;
          cnt_d   = `TCS_CNT_ZERO;
        end else if (cmd_force_one || (samp_q && match_one)) begin
          state_d = TCS_ST_SEEK2;
        end
      end
      TCS_ST_SEEK2: begin
        if (cmd_force_two) begin
          state_d = TCS_ST_POST;
          cnt_d   = `TCS_CNT_ZERO;
        end else if (samp_q && match_two) begin
          if (evt_mode) begin
            if (evt_q == event_delay_count_q) begin
              state_d = TCS_ST_POST;
              cnt_d   = `TCS_CNT_ZERO;
            end else begin
              evt_d   = evt_q + `TCS_CNT_ONE;
            end
          end else if (clock_delay_count_q == `TCS_CNT_ZERO) begin
            state_d = TCS_ST_POST;
            cnt_d   = `TCS_CNT_ZERO;
          end else begin
            state_d = TCS_ST_DELAY;
            cnt_d   = clock_delay_count_q;
          end
        end
      end
      TCS_ST_DELAY: begin
        if (cmd_force_two) begin
          state_d = TCS_ST_POST;
          cnt_d   = `TCS_CNT_ZERO;
        end else if (samp_q) begin
          if (cnt_q == `TCS_CNT_ONE) begin
            state_d = TCS_ST_POST;
            cnt_d   = `TCS_CNT_ZERO;
          end else begin
            cnt_d   = cnt_q - `TCS_CNT_ONE;
          end
        end
      end
      TCS_ST_POST: begin
        if (samp_q) begin
          cnt_d = cnt_q + `TCS_CNT_ONE;
          if (cnt_q == `TCS_POST_LAST) begin
            state_d = TCS_ST_DONE;
          end
        end
      end
    endcase
    if (cmd_stop && (state_q != TCS_ST_IDLE)) begin
      state_d = TCS_ST_DONE;
    end
    if (cmd_arm) begin
      state_d = TCS_ST_FLUSH;
      cnt_d   = `TCS_CNT_ZERO;
      evt_d   = `TCS_CNT_ZERO;
    end
  end

  // sequencer registers; pointer freezes once the recording ends
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_q  <= TCS_ST_IDLE;
      cnt_q    <= 14'h0000;
      evt_q    <= 14'h0000;
      wr_ptr_q <= 6'h00;
      trig_q   <= 1'b0;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      evt_q    <= evt_d;
      trig_q   <= (state_d == TCS_ST_POST);
      if (samp_q && recording) begin
        wr_ptr_q <= wr_ptr_q + 6'h01;
      end
    end
  end

  // store port: one write per qualified sample while recording
  assign mem_bus.we    = samp_q & recording;
  assign mem_bus.waddr = wr_ptr_q;
  assign mem_bus.wdata = word_q;
  // oldest word sits at the write pointer, so index 31 is the trigger word
  assign mem_bus.raddr = wr_ptr_q + rd_index_q;

  assign HREADYOUT   = hready_q;
  assign HRDATA      = hrdata_q;
  assign HRESP       = 1'b0;
  assign TRIGGER_OUT = trig_q;
endmodule
`default_nettype wire

// ==== src/tcs_regs.svh ====
// register map, field positions, reset values and counts of the capture sequencer
// assumes a 32-bit AHB-Lite slave decoding the low address byte only
`ifndef TCS_REGS_SVH
`define TCS_REGS_SVH

`define TCS_WORD_W        27
`define TCS_DEPTH         64
`define TCS_PTR_W         6
`define TCS_DELAY_W       14

// byte offsets
`define TCS_OFS_CONFIG    8'h00
`define TCS_OFS_COMMAND   8'h04
`define TCS_OFS_STATUS    8'h08
`define TCS_OFS_FIRST_PAT 8'h0C
`define TCS_OFS_FIRST_MSK 8'h10
`define TCS_OFS_SECND_PAT 8'h14
`define TCS_OFS_SECND_MSK 8'h18
`define TCS_OFS_POLARITY  8'h1C
`define TCS_OFS_CLK_DLY   8'h20
`define TCS_OFS_EVT_DLY   8'h24
`define TCS_OFS_RD_INDEX  8'h28
`define TCS_OFS_RD_DATA   8'h2C

// configuration bits
`define TCS_CFG_FALLING   0
`define TCS_CFG_QUAL_ONE  1
`define TCS_CFG_QUAL_TWO  2
`define TCS_CFG_EVENT     3
`define TCS_CFG_RESET     4'h6

// command bits (write-only pulses)
`define TCS_CMD_ARM       0
`define TCS_CMD_FORCE_ONE 1
`define TCS_CMD_FORCE_TWO 2
`define TCS_CMD_STOP      3

// status fields
`define TCS_STS_DONE      8
`define TCS_STS_TRIGGER   9

// probe bit positions
`define TCS_BIT_DIR       24
`define TCS_BIT_PQ_ONE    25
`define TCS_BIT_PQ_TWO    26

// sample counts
`define TCS_FLUSH_LAST    14'h003F
`define TCS_POST_LAST     14'h001F
`define TCS_CNT_ONE       14'h0001
`define TCS_CNT_ZERO      14'h0000

`endif

// ==== src/tcs_pkg.sv ====
// types shared by the capture sequencer files
// assumes tcs_regs.svh is on the include path
`default_nettype none
package tcs_pkg;
  typedef enum logic [6:0] {
    TCS_ST_IDLE  = 7'h01,
    TCS_ST_FLUSH = 7'h02,
    TCS_ST_SEEK1 = 7'h04,
    TCS_ST_SEEK2 = 7'h08,
    TCS_ST_DELAY = 7'h10,
    TCS_ST_POST  = 7'h20,
    TCS_ST_DONE  = 7'h40
  } tcs_state_t;
endpackage
`default_nettype wire

// ==== src/tcs_mem_if.sv ====
// write and read port bundle between sequencer and capture store
// assumes both ends run on the same system clock
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"
interface tcs_mem_if;
  logic                      we;
  logic [`TCS_PTR_W-1:0]     waddr;
  logic [`TCS_WORD_W-1:0]    wdata;
  logic [`TCS_PTR_W-1:0]     raddr;
  logic [`TCS_WORD_W-1:0]    rdata;
  modport writer (output we, output waddr, output wdata, output raddr, input rdata);
  modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface
`default_nettype wire

// ==== src/tcs_capture_mem.sv ====
// capture store: 64 words of 27 bits, registered read
// assumes one write and one read per cycle on the system clock
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_capture_mem (
  input wire logic    clk,
  input wire logic    rst,
  tcs_mem_if.store    port
);
  logic [`TCS_WORD_W-1:0] mem [`TCS_DEPTH];

  // array itself has no reset, the flush phase refills it
  always_ff @(posedge clk) begin
    if (port.we) begin
      mem[port.waddr] <= port.wdata;
    end
  end

  // read data always out of a register
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      port.rdata <= 27'h0000000;
    end else begin
      port.rdata <= mem[port.raddr];
    end
  end
endmodule
`default_nettype wire

// ==== bench/tcs_checker.sv ====
// pin-level checks of the capture sequencer: bus answer, read data, trigger pin
// assumes it is bound to tcs_top and sees its ports only
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"
module tcs_checker (
  input wire logic        SYS_CLK,
  input wire logic        RST,
  input wire logic        HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0]  HTRANS,
  input wire logic        HWRITE,
  input wire logic        HREADY,
  input wire logic [31:0] HRDATA,
  input wire logic        HREADYOUT,
  input wire logic        HRESP,
  input wire logic        EXT_CLK,
  input wire logic        TRIGGER_OUT
);
  // accepted transfers; ages saturate so a long quiet spell reads as 15
  wire       acc         = HSEL && HTRANS[1] && HREADY;
  wire       rd_acc      = acc && !HWRITE;
  wire       rd_sts      = rd_acc && (HADDR[7:0] == `TCS_OFS_STATUS);
  logic      ext_seen_q;
  logic [3:0] edge_age_q;
  logic [3:0] write_age_q;
  wire [3:0] edge_age_d  = (ext_seen_q != EXT_CLK) ? 4'h0 : edge_age_q + {3'h0, ~&edge_age_q};
  wire [3:0] write_age_d = (acc && HWRITE) ? 4'h0 : write_age_q + {3'h0, ~&write_age_q};

  // trigger pin may only move shortly after a probe clock edge or a command
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      ext_seen_q  <= 1'b0;
      edge_age_q  <= 4'hF;
      write_age_q <= 4'hF;
    end else begin
      ext_seen_q  <= EXT_CLK;
      edge_age_q  <= edge_age_d;
      write_age_q <= write_age_d;
    end
  end

  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);

  AST_WAIT_ONE: assert property (acc |=> !HREADYOUT ##1 HREADYOUT)
    else $error("transfer not answered after exactly one wait state");
  AST_OKAY_ONLY: assert property (HRESP == 1'b0)
    else $error("slave answered with an error response");
  AST_RDATA_STANDS: assert property (!$past(rd_acc, 2) |-> $stable(HRDATA))
    else $error("read data moved without a read");
  AST_RESET_QUIET: assert property ($fell(RST) |-> HREADYOUT && !TRIGGER_OUT && HRDATA == 32'h0)
    else $error("outputs not at rest after reset");
  AST_TRIG_RISE_CAUSE: assert property ($rose(TRIGGER_OUT) |-> edge_age_q <= 4'hC || write_age_q <= 4'h6)
    else $error("trigger rose with no sample or command");
  AST_TRIG_FALL_CAUSE: assert property ($fell(TRIGGER_OUT) |-> edge_age_q <= 4'hC || write_age_q <= 4'h6)
    else $error("trigger fell with no sample or command");
  AST_STS_TRIG: assert property ($past(rd_sts, 2) |-> HRDATA[`TCS_STS_TRIGGER] == $past(TRIGGER_OUT))
    else $error("status trigger bit differs from the pin");
  AST_DONE_TRIG_LOW: assert property ($past(rd_sts, 2) && HRDATA[8] |-> !HRDATA[9] && HRDATA[6:0] == 7'h40)
    else $error("done reported with trigger high or wrong state");
  AST_STATE_ONEHOT: assert property ($past(rd_sts, 2) |-> $onehot(HRDATA[6:0]))
    else $error("sequencer state not one-hot");

  COV_TRIG_RISE: cover property ($rose(TRIGGER_OUT));
  COV_TRIG_FALL: cover property ($fell(TRIGGER_OUT));
  COV_DONE_READ: cover property (rd_sts ##2 HRDATA[8]);
endmodule

bind tcs_top tcs_checker i_checker (
  .SYS_CLK(SYS_CLK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
  .HWRITE(HWRITE), .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
  .HRESP(HRESP), .EXT_CLK(EXT_CLK), .TRIGGER_OUT(TRIGGER_OUT));
`default_nettype wire

// ==== bench/tcs_bus_model.sv ====
// far side: a synchronous bus under test with its own record clock
// assumes the bench calls run() while the sequencer waits for samples
`timescale 1ns/10ps
`default_nettype none
module tcs_bus_model (
  output var logic [26:0] probe,
  output var logic        ext_clk,
  output var logic        qual_one,
  output var logic        qual_two
);
  // unused qualifiers rest high between frames
  initial begin
    probe    = 27'h0;
    ext_clk  = 1'b0;
    qual_one = 1'b1;
    qual_two = 1'b1;
  end

  // n qualified words base+k; data moves on the inactive edge, clock still after
  task automatic run(input int n, input logic [26:0] base, input logic fall,
                     input logic lvl_one, input logic lvl_two, input logic skip,
                     input realtime half);
    int k;
    k = 0;
    ext_clk = fall;
    for (int s = 0; k < n; s++) begin
      if (skip && s[1:0] == 2'h3) begin
        probe    = ~(base + 27'(k)); // junk on a disqualified edge
        qual_one = s[2] ? ~lvl_one : lvl_one; // each qualifier takes its turn
        qual_two = s[2] ? lvl_two : ~lvl_two;
      end else begin
        probe    = base + 27'(k);
        qual_one = lvl_one;
        qual_two = lvl_two;
        k++;
      end
      #(half) ext_clk = ~fall;
      #(half) ext_clk = fall;
    end
    probe    = ~probe; // released lines show no stale word
    qual_one = 1'b1;
    qual_two = 1'b1;
  endtask
endmodule
`default_nettype wire

// ==== bench/trigger_capture_sequencer_test.sv ====
// self-checking bench: bus tasks, recordings fed by the bus model, readback
// assumes tcs_top, tcs_bus_model and tcs_checker are compiled first
`timescale 1ns/10ps
`default_nettype none
`include "tcs_regs.svh"
module trigger_capture_sequencer_test import tcs_pkg::*;;
  localparam logic [26:0] base_word = 27'h3C50000;
  logic        sys_clk = 1'b0;
  logic        rst     = 1'b1;
  logic        hsel    = 1'b0;
  logic [31:0] haddr   = 32'h0;
  logic [1:0]  htrans  = 2'h0;
  logic        hwrite  = 1'b0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] regs [10];
  wire  [31:0] hrdata;
  wire         hready;
  wire         trig;
  wire  [26:0] probe;
  wire         ext_clk;
  wire         qa;
  wire         qb;
  int          bad_count = 0;
  int          n_tests   = 0;

  always #4 sys_clk = ~sys_clk;

  tcs_top i_dut (
    .SYS_CLK(sys_clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
    .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata),
    .HREADYOUT(hready), .HRESP(), .PROBE_IN(probe), .EXT_CLK(ext_clk),
    .SAMPLE_QUALIFIER_ONE(qa), .SAMPLE_QUALIFIER_TWO(qb), .TRIGGER_OUT(trig));
  tcs_bus_model i_sut (.probe(probe), .ext_clk(ext_clk), .qual_one(qa), .qual_two(qb));

  task automatic end_of_test();
    $display("checks %0d, mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  // single word transfer; address held until ready, data until ready again
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge sys_clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge sys_clk);
    while (hready !== 1'b1) @(posedge sys_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string what);
    logic [31:0] v;
    xfer(1'b0, a, 32'h0, v);
    check(what, v, exp);
  endtask

  // regs[] mirrors offsets 0x00..0x24; command and status slots skipped
  task automatic program_regs();
    for (int i = 0; i < 10; i++)
      if (i == 0 || i > 2) wr(8'(4 * i), regs[i]);
  endtask

  // arm, feed words, wait for done, then compare the whole store
  task automatic capture(input int tpos, input logic prog, input logic skip,
                         input realtime half);
    logic [31:0] v;
    logic [26:0] w;
    if (prog) program_regs();
    wr(`TCS_OFS_COMMAND, 32'h1);
    i_sut.run(tpos + 40, base_word, regs[0][0], regs[0][1], regs[0][2], skip, half);
    v = 32'h0;
    for (int n = 0; n < 50 && v[8] !== 1'b1; n++) xfer(1'b0, `TCS_OFS_STATUS, 32'h0, v);
    check("status", v, {22'h0, 3'b010, TCS_ST_DONE});
    check("trigger pin", {31'h0, trig}, 32'h0);
    for (int j = 0; j < 64; j++) begin
      w = (base_word + 27'(tpos - 31 + j)) ^ regs[7][26:0];
      wr(`TCS_OFS_RD_INDEX, 32'(j));
      rd(`TCS_OFS_RD_DATA, {5'h0, w}, "stored word");
    end
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    rd(`TCS_OFS_CONFIG, {28'h0, `TCS_CFG_RESET}, "config");
    rd(`TCS_OFS_FIRST_MSK, 32'h0, "first mask");
    rd(`TCS_OFS_STATUS, {25'h0, TCS_ST_IDLE}, "idle status");
    rd(8'h40, 32'h0, "unmapped");
    // low six bits only: word 36 hits inside the flush and must be passed over
    regs = '{32'h2, 0, 0, 32'h7FFFFFF, 0, 32'h24, 32'h3F, 32'h0F0F0C0, 0, 0};
    capture(100, 1'b1, 1'b1, 62.5);
    // falling edge, full 27-bit pattern, clock delay 5
    regs = '{32'h7, 0, 0, 0, 0, 32'(base_word + 27'h5A), 32'h7FFFFFF, 0, 32'h5, 0};
    capture(95, 1'b1, 1'b0, 62.5);
    // first stage at word 81, every fourth word matches the second, event delay 2
    regs = '{32'hE, 0, 0, 32'(base_word + 27'h51), 32'hFFFF, 0, 32'h3, 0, 0, 32'h2};
    capture(92, 1'b1, 1'b0, 62.5);
    capture(92, 1'b0, 1'b0, 62.5);
    // first stage never matches: stop, then force both stages by hand
    regs = '{32'h6, 0, 0, 0, 32'h7FFFFFF, 0, 0, 0, 0, 0};
    program_regs();
    wr(`TCS_OFS_COMMAND, 32'h1);
    i_sut.run(70, base_word, 1'b0, 1'b1, 1'b1, 1'b0, 62.5);
    rd(`TCS_OFS_STATUS, {25'h0, TCS_ST_SEEK1}, "seek first");
    wr(`TCS_OFS_COMMAND, 32'h8);
    rd(`TCS_OFS_STATUS, {22'h0, 3'b010, TCS_ST_DONE}, "stopped");
    wr(`TCS_OFS_COMMAND, 32'h1);
    i_sut.run(70, base_word, 1'b0, 1'b1, 1'b1, 1'b0, 62.5);
    wr(`TCS_OFS_COMMAND, 32'h2);
    rd(`TCS_OFS_STATUS, {25'h0, TCS_ST_SEEK2}, "forced first");
    wr(`TCS_OFS_COMMAND, 32'h4);
    rd(`TCS_OFS_STATUS, {22'h0, 3'b100, TCS_ST_POST}, "forced second");
    check("trigger in post", {31'h0, trig}, 32'h1);
    i_sut.run(40, base_word, 1'b0, 1'b1, 1'b1, 1'b0, 62.5);
    rd(`TCS_OFS_STATUS, {22'h0, 3'b010, TCS_ST_DONE}, "post done");
    check("trigger after post", {31'h0, trig}, 32'h0);
    end_of_test();
  end

  // hang guard, well beyond the roughly 15000 cycles the sequence needs
  initial begin
    repeat (60000) @(posedge sys_clk);
    bad_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
